/* File: fan_regs_pkg.sv */
package fan_regs_pkg;

  // ==========================================================
  // register indices (the register-select code of the host port)
  // ==========================================================
  localparam logic [2:0] IDX_FAN_STATUS = 3'h0;
  localparam logic [2:0] IDX_DUTY_SETTING = 3'h1;
  localparam logic [2:0] IDX_MAKER_CODE = 3'h2;
  localparam logic [2:0] IDX_VARIANT_CODE = 3'h3;

  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int FAULT_FLAG_BIT = 0;
  localparam int INPUT_OPEN_BIT = 2;
  localparam int FAULT_CLEAR_BIT = 7;
  localparam logic [3:0] DUTY_RESET = 4'h2;
  localparam logic [7:0] MAKER_CODE_VAL = 8'hA5; // arbitrary value
  localparam logic [1:0] VARIANT_CODE_VAL = 2'h1; // arbitrary value

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    SRC_REGISTER = 2'b00,
    SRC_ANALOG = 2'b01,
    SRC_FALLBACK = 2'b10
  } duty_src_t;

endpackage : fan_regs_pkg

/* File: fan_status_duty_regs.sv */
`timescale 1ns/1ns
module fan_status_duty_regs #(
  parameter int SPEED_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fan_regs_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic input_open_sense,
  input wire logic [3:0] analog_duty_code,
  input wire logic host_control_sel,
  input wire logic fault_clear_bit,
  input wire logic [SPEED_W-1:0] measured_speed,
  input wire logic [SPEED_W-1:0] speed_threshold,
  output logic fault_alert_n,
  output logic [3:0] pwm_duty_code,
  output fan_regs_pkg::duty_src_t duty_src
);
  import fan_regs_pkg::*;

  logic input_open_flag_r;
  logic sampled_r;
  logic fan_fault_flag_r;
  logic [3:0] duty_setting_r;
  logic speed_low;
  logic fault_set;
  logic [3:0] duty_nxt;
  duty_src_t src_nxt;
  logic [7:0] status_word;

  // ==========================================================
  // power-up sense of the analog input
  // ==========================================================
  // caught once after reset release, not during reset, so the async-free
  // reset never loads a port value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sampled_r <= 1'b0;
      input_open_flag_r <= 1'b0;
    end else if (!sampled_r) begin
      sampled_r <= 1'b1;
      input_open_flag_r <= input_open_sense;
    end
  end

  // ==========================================================
  // fan fault flag and alert
  // ==========================================================
  assign speed_low = measured_speed < speed_threshold;
  assign fault_set = speed_low;

  // set wins over clear so a fault arriving during the clear is kept
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fan_fault_flag_r <= 1'b0;
    end else if (fault_set) begin
      fan_fault_flag_r <= 1'b1;
    end else if (fault_clear_bit) begin
      fan_fault_flag_r <= 1'b0;
    end
  end

  // combinational path so the alert falls in the setting cycle
  assign fault_alert_n = !(fan_fault_flag_r || fault_set);

  // ==========================================================
  // duty register
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      duty_setting_r <= DUTY_RESET;
    end else if (reg_req.wr && reg_req.idx == IDX_DUTY_SETTING) begin
      duty_setting_r <= reg_req.wdata[3:0];
    end
  end

  // ==========================================================
  // drive source selection
  // ==========================================================
  // code n means 30 + n*4.67 percent, linear so monotonic by construction
  always_comb begin
    if (host_control_sel) begin
      src_nxt = SRC_REGISTER;
      duty_nxt = duty_setting_r;
    end else if (input_open_flag_r) begin
      src_nxt = SRC_FALLBACK;
      duty_nxt = DUTY_RESET;
    end else begin
      src_nxt = SRC_ANALOG;
      duty_nxt = analog_duty_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_duty_code <= DUTY_RESET;
      duty_src <= SRC_REGISTER;
    end else begin
      pwm_duty_code <= duty_nxt;
      duty_src <= src_nxt;
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  // status image built from the named bit positions; unused bits stay 0
  always_comb begin
    status_word = 8'h00;
    status_word[FAULT_FLAG_BIT] = fan_fault_flag_r;
    status_word[INPUT_OPEN_BIT] = input_open_flag_r;
  end

  // bit 1 of status is unimplemented; driven 0 here but undefined to software
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.idx)
        IDX_FAN_STATUS: reg_rdata <= status_word;
        IDX_DUTY_SETTING: reg_rdata <= {4'h0, duty_setting_r};
        IDX_MAKER_CODE: reg_rdata <= MAKER_CODE_VAL;
        IDX_VARIANT_CODE: reg_rdata <= {6'h00, VARIANT_CODE_VAL};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  property p_fault_set;
    @(posedge ref_clk) disable iff (!rst_n)
      speed_low |=> fan_fault_flag_r;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag missed low speed");

  property p_alert_same_cycle;
    @(posedge ref_clk) disable iff (!rst_n)
      speed_low |-> !fault_alert_n;
  endproperty
  a_alert_same_cycle: assert property (p_alert_same_cycle)
    else $error("alert not low with fault");

  property p_fault_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (fan_fault_flag_r && !fault_clear_bit) |=> fan_fault_flag_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault flag dropped without clear");

  property p_fault_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (fault_clear_bit && !speed_low) |=> !fan_fault_flag_r;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault flag not cleared");

  property p_open_held;
    @(posedge ref_clk) disable iff (!rst_n)
      sampled_r |=> $stable(input_open_flag_r);
  endproperty
  a_open_held: assert property (p_open_held)
    else $error("input-open flag changed after power-up");

  property p_fallback;
    @(posedge ref_clk) disable iff (!rst_n)
      (!host_control_sel && input_open_flag_r) |=> pwm_duty_code == DUTY_RESET;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("open input did not give default duty");

  property p_host_duty;
    @(posedge ref_clk) disable iff (!rst_n)
      host_control_sel |=> pwm_duty_code == $past(duty_setting_r);
  endproperty
  a_host_duty: assert property (p_host_duty)
    else $error("drive did not follow duty register");

  sequence s_duty_write;
    reg_req.wr && reg_req.idx == IDX_DUTY_SETTING && !reg_req.rd;
  endsequence
  property p_duty_write;
    @(posedge ref_clk) disable iff (!rst_n)
      s_duty_write |=> duty_setting_r == $past(reg_req.wdata[3:0]);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty register write lost");

  property p_maker_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.idx == IDX_MAKER_CODE) |=>
        reg_rdata == MAKER_CODE_VAL;
  endproperty
  a_maker_read: assert property (p_maker_read)
    else $error("maker code read wrong");

  // writes to any other index must leave the duty register alone
  property p_duty_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.idx != IDX_DUTY_SETTING) |=>
        $stable(duty_setting_r);
  endproperty
  a_duty_keep: assert property (p_duty_keep)
    else $error("duty register changed by a foreign write");

  property p_variant_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.idx == IDX_VARIANT_CODE) |=>
        reg_rdata == {6'h00, VARIANT_CODE_VAL};
  endproperty
  a_variant_read: assert property (p_variant_read)
    else $error("variant code read wrong");

  // the capture edge must take the sense level seen just before it
  property p_open_capture;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(sampled_r) |-> input_open_flag_r == $past(input_open_sense);
  endproperty
  a_open_capture: assert property (p_open_capture)
    else $error("input-open flag did not take the sense level");

  // a clear with the speed good, followed by a good cycle, lifts the alert
  sequence s_clear_quiet;
    fault_clear_bit && !speed_low;
  endsequence
  property p_alert_release;
    @(posedge ref_clk) disable iff (!rst_n)
      s_clear_quiet ##1 !speed_low |-> fault_alert_n;
  endproperty
  a_alert_release: assert property (p_alert_release)
    else $error("alert still low after fault clear");

endmodule : fan_status_duty_regs

/* File: fan_host_model.sv */
`timescale 1ns/1ns
// =====
// host side: one strobe per request
module fan_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output fan_regs_pkg::reg_req_t reg_req,
  output logic fault_clear_bit
);
  import fan_regs_pkg::*;
  initial begin
    reg_req = '0;
    fault_clear_bit = 1'b0;
  end
  // released fields get inverted so stale data is never trusted
  task automatic wr(input logic [2:0] i, input logic [7:0] v);
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, idx: i, wdata: v};
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, idx: ~i, wdata: ~v};
  endtask : wr
  // answer is registered, taken once settled
  task automatic rd(input logic [2:0] i, output logic [7:0] v);
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, idx: i, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, idx: ~i, wdata: 8'hFF};
    @(negedge ref_clk);
    v = reg_rdata;
  endtask : rd
  // one-cycle pulse on the clear bit
  task automatic clr();
    @(posedge ref_clk);
    fault_clear_bit <= 1'b1;
    @(posedge ref_clk);
    fault_clear_bit <= 1'b0;
  endtask : clr
endmodule : fan_host_model

/* File: tb_fan_status_duty_regs.sv */
`timescale 1ns/1ns
module tb_fan_status_duty_regs;
  import fan_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op = 1'b1;
  logic sel = 1'b0;
  logic clr;
  logic alert_n;
  logic [3:0] ana = 4'h0;
  logic [3:0] c;
  logic [3:0] pwm;
  logic [7:0] spd = 8'hFF;
  logic [7:0] thr = 8'h10;
  logic [7:0] d;
  logic [7:0] rdata;
  reg_req_t req;
  duty_src_t src;
  int error_cnt = 0;
  int compares = 0;
  always #20 ref_clk = ~ref_clk;
  fan_host_model host (.ref_clk(ref_clk), .reg_rdata(rdata),
    .reg_req(req), .fault_clear_bit(clr));
  fan_status_duty_regs #(.SPEED_W(8)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .input_open_sense(op), .analog_duty_code(ana),
    .host_control_sel(sel), .fault_clear_bit(clr),
    .measured_speed(spd), .speed_threshold(thr),
    .fault_alert_n(alert_n), .pwm_duty_code(pwm), .duty_src(src));
  // =====
  // expectations and checks
  function automatic logic [7:0] drv(logic h, logic o, logic [3:0] r);
    return {4'h0, h ? r : (o ? DUTY_RESET : ana)};
  endfunction : drv
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // reset held 8 cycles; sense input captured on release
  task automatic do_reset(logic o);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    op <= o;
    sel <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    op <= ~o;
    ana <= 4'($urandom);
  endtask : do_reset
  // =====
  // main sequence
  initial begin
    void'($urandom(34444));
    do_reset(1'b1);
    host.rd(IDX_FAN_STATUS, d);
    chk("open", 8'h1, {7'h0, d[INPUT_OPEN_BIT]});
    chk("src", {6'h0, SRC_FALLBACK}, {6'h0, src});
    chk("pwm", drv(1'b0, 1'b1, 4'h0), {4'h0, pwm});
    @(posedge ref_clk);
    sel <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      c = (i < 16) ? i[3:0] : 4'($urandom);
      host.wr(IDX_DUTY_SETTING, {4'($urandom), c});
      host.rd(IDX_DUTY_SETTING, d);
      chk("duty", {4'h0, c}, {4'h0, d[3:0]});
      chk("pwm", drv(1'b1, 1'b0, c), {4'h0, pwm});
      chk("src", {6'h0, SRC_REGISTER}, {6'h0, src});
    end
    host.wr(IDX_MAKER_CODE, ~MAKER_CODE_VAL);
    host.rd(IDX_MAKER_CODE, d);
    chk("maker", MAKER_CODE_VAL, d);
    host.rd(IDX_DUTY_SETTING, d);
    chk("duty", {4'h0, c}, {4'h0, d[3:0]});
    host.rd(IDX_VARIANT_CODE, d);
    chk("variant", {6'h0, VARIANT_CODE_VAL}, d);
    host.rd(3'h5, d);
    chk("unmapped", 8'h00, d);
    @(posedge ref_clk);
    spd <= thr - 8'h01;
    @(negedge ref_clk);
    chk("alert", 8'h0, {7'h0, alert_n});
    @(posedge ref_clk);
    spd <= thr;
    host.rd(IDX_FAN_STATUS, d);
    chk("fault", 8'h1, {7'h0, d[FAULT_FLAG_BIT]});
    chk("alert", 8'h0, {7'h0, alert_n});
    host.clr();
    host.rd(IDX_FAN_STATUS, d);
    chk("fault", 8'h0, {7'h0, d[FAULT_FLAG_BIT]});
    chk("alert", 8'h1, {7'h0, alert_n});
    do_reset(1'b0);
    host.rd(IDX_FAN_STATUS, d);
    chk("open", 8'h0, {7'h0, d[INPUT_OPEN_BIT]});
    chk("src", {6'h0, SRC_ANALOG}, {6'h0, src});
    chk("pwm", drv(1'b0, 1'b0, 4'h0), {4'h0, pwm});
    final_report();
  end
  // watchdog: run needs well under 2000 cycles
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule : tb_fan_status_duty_regs
